// >>> design/fsh_pkg.sv
// Shared constants and types for the status, write-protect and pause block
// What this block does
// [RULE1] Host keeps chip enable low to pause
// [RULE2] Pause begins on low input with clock low
// [RULE3] Pause ends on high input with clock low
// [RULE4] Paused: output floats, clock and data ignored
// [RULE5] Chip enable high while paused resets interface
// [RULE6] Paused while input low; resume needs enable low
// [RULE7] Protect pin low plus lock rejects status writes
// [RULE8] Protection bits and lock refuse writes
// [RULE9] Bit 0 busy, read-only, zero at reset
// [RULE10] Bit 1 mirrors write-enable latch, zero at reset
// [RULE11] Bits 2-4 protection level, reset to ones
// [RULE12] Bit 5 reserved, reads zero, writes ignored
// [RULE13] Bit 6 auto-increment mode flag, read-only
// [RULE14] Bit 7 lock, zero at reset, freezes level while protect pin low
// [RULE15] Status write changes only level and lock
// [RULE16] All status bits volatile, reset to defaults
// [RULE17] During busy only status reads are served
// [RULE18] Whole-array erase only when level is zero
// [RULE19] Level code selects protected upper fraction
// [RULE20] Status write completion clears write-enable latch
// [RULE21] After pause reset wait for new enable fall
package fsh_pkg;
  localparam int STAT_BUSY = 0;
  localparam int STAT_WEL = 1;
  localparam int STAT_LVL_LO = 2;
  localparam int STAT_LVL_HI = 4;
  localparam int STAT_RSVD = 5;
  localparam int STAT_AAI = 6;
  localparam int STAT_LOCK = 7;
  localparam logic [2:0] LVL_RESET = 3'h7;
  localparam logic LOCK_RESET = 1'h0;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam int ADDR_W = 21;
  localparam int BLOCK_W = 5;
  localparam int BLOCK_LSB = 16;
  localparam logic [2:0] LVL_ALL = 3'h6;

  typedef struct packed {
    logic ce_b;
    logic sck;
    logic si;
    logic hold_b;
    logic wp_b;
  } fsh_pins_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic chip;
  } fsh_chk_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPC = 3'h1,
    ST_WDATA = 3'h2,
    ST_WDONE = 3'h3,
    ST_RDSR = 3'h4,
    ST_SKIP = 3'h5
  } fsh_state_t;
endpackage

// >>> design/fsh_status_hold.sv
// Serial status register, write-protect gating and pause handling
`timescale 1ns/100ps
module fsh_status_hold
  import fsh_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire fsh_pkg::fsh_pins_t pins,
  input wire logic eng_busy,
  input wire logic aai_active,
  input wire logic wel_set,
  input wire logic wel_clr,
  input wire fsh_pkg::fsh_chk_t chk,
  output logic so_q,
  output logic so_oe_q,
  output logic held_q,
  output logic [7:0] status_q,
  output logic [7:0] cmd_byte_q,
  output logic cmd_valid_q,
  output logic deny_q
);
  import fsh_pkg::*;

  // Level code to first protected block; codes 6 and 7 cover the whole array
  function automatic logic is_protected(input logic [2:0] lvl, input logic [BLOCK_W-1:0] blk);
    logic [BLOCK_W:0] first;
    first = 6'h20;
    if (lvl >= LVL_ALL) begin
      first = 6'h00;
    end else if (lvl != 3'h0) begin
      first = 6'h20 - (6'h01 << (lvl - 3'h1));
    end
    return {1'b0, blk} >= first;
  endfunction

  fsh_pins_t s1_q, s2_q;
  logic sck_prev_q, ce_prev_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '{ce_b: 1'b1, sck: 1'b0, si: 1'b0, hold_b: 1'b1, wp_b: 1'b1};
      s2_q <= '{ce_b: 1'b1, sck: 1'b0, si: 1'b0, hold_b: 1'b1, wp_b: 1'b1};
      sck_prev_q <= 1'b0;
      ce_prev_q <= 1'b1;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      sck_prev_q <= s2_q.sck;
      ce_prev_q <= s2_q.ce_b;
    end
  end

  logic sck_rise, sck_fall, ce_rise, ce_fall;
  assign sck_rise = s2_q.sck && !sck_prev_q;
  assign sck_fall = !s2_q.sck && sck_prev_q;
  assign ce_rise = s2_q.ce_b && !ce_prev_q;
  assign ce_fall = !s2_q.ce_b && ce_prev_q;

  fsh_state_t st_q, st_d;
  logic [7:0] sh_q, sh_d, out_q, out_d, cmd_byte_d;
  logic [2:0] bit_q, bit_d;
  logic held_d, so_d, so_oe_d, cmd_valid_d, deny_d, busy_q, busy_d, wel_q, wel_d, aai_q, aai_d;
  logic [2:0] lvl_q, lvl_d;
  logic lock_q, lock_d;
  logic [7:0] status_d;
  logic wr_go, wr_ok, active;

  // A status write is committed when chip enable rises after the data byte
  assign wr_go = ce_rise && st_q == ST_WDONE;
  assign wr_ok = s2_q.wp_b || !lock_q; // see [RULE7]
  assign active = !s2_q.ce_b && !held_q;

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    bit_d = bit_q;
    out_d = out_q;
    held_d = held_q;
    so_d = so_q;
    so_oe_d = so_oe_q;
    cmd_byte_d = cmd_byte_q;
    cmd_valid_d = 1'b0;
    busy_d = eng_busy; // see [RULE9]
    aai_d = aai_active; // see [RULE13]
    wel_d = wel_q;
    lvl_d = lvl_q;
    lock_d = lock_q;
    // Pause is only recognised while selected; entry and exit both wait for clock low
    if (!s2_q.ce_b && !s2_q.sck) begin // see [RULE1]
      if (!held_q && !s2_q.hold_b) begin
        held_d = 1'b1; // see [RULE2]
      end else if (held_q && s2_q.hold_b) begin
        held_d = 1'b0; // see [RULE3] [RULE6]
      end
    end
    if (s2_q.ce_b) begin
      // Deselect ends any sequence; when paused this is the interface reset
      held_d = 1'b0; // see [RULE5]
      st_d = ST_IDLE; // see [RULE21]
      bit_d = 3'h0;
      so_oe_d = 1'b0;
    end else if (held_q || held_d) begin
      so_oe_d = 1'b0; // see [RULE4]
    end else begin
      if (ce_fall) begin
        st_d = ST_OPC;
        bit_d = 3'h0;
      end
      if (active && sck_rise && st_q != ST_IDLE) begin
        sh_d = {sh_q[6:0], s2_q.si};
        bit_d = bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          case (st_q)
            ST_OPC: begin
              cmd_byte_d = {sh_q[6:0], s2_q.si};
              // While busy, no opcode raises cmd_valid_q; only a status read is still answered
              cmd_valid_d = !busy_q; // see [RULE17]
              if (cmd_byte_d == OP_STATUS_READ) begin
                st_d = ST_RDSR;
              end else if (cmd_byte_d == OP_STATUS_WRITE && !busy_q) begin
                st_d = ST_WDATA;
              end else begin
                st_d = ST_SKIP;
              end
            end
            ST_WDATA: st_d = ST_WDONE;
            // Status read keeps answering byte after byte until deselect
            ST_RDSR: st_d = ST_RDSR; // see [RULE17]
            default: st_d = ST_SKIP;
          endcase
        end
      end
      if (active && sck_fall && st_q == ST_RDSR) begin
        // Status is resampled at each byte boundary so polling sees busy drop
        if (bit_q == 3'h0) begin
          so_d = status_q[7];
          out_d = {status_q[6:0], 1'b0};
        end else begin
          so_d = out_q[7];
          out_d = {out_q[6:0], 1'b0};
        end
        so_oe_d = 1'b1; // see [RULE17]
      end
    end
    if (wr_go && wr_ok) begin
      lvl_d = sh_q[STAT_LVL_HI:STAT_LVL_LO]; // see [RULE15] [RULE14]
      lock_d = sh_q[STAT_LOCK]; // see [RULE8]
    end
    // Latch set wins over a clear landing in the same cycle
    if (wr_go || wel_clr) begin
      wel_d = 1'b0; // see [RULE20]
    end
    if (wel_set) begin
      wel_d = 1'b1; // see [RULE10]
    end
    status_d = 8'h00;
    status_d[STAT_BUSY] = busy_d;
    status_d[STAT_WEL] = wel_d;
    status_d[STAT_LVL_HI:STAT_LVL_LO] = lvl_d;
    status_d[STAT_RSVD] = 1'b0; // see [RULE12]
    status_d[STAT_AAI] = aai_d;
    status_d[STAT_LOCK] = lock_d;
    // Refuse program and erase on protected blocks; whole-array erase needs level zero
    if (chk.chip) begin
      deny_d = lvl_q != 3'h0; // see [RULE18]
    end else begin
      deny_d = is_protected(lvl_q, chk.addr[BLOCK_LSB +: BLOCK_W]); // see [RULE19] [RULE8]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      sh_q <= 8'h00;
      bit_q <= 3'h0;
      out_q <= 8'h00;
      held_q <= 1'b0;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
      cmd_byte_q <= 8'h00;
      cmd_valid_q <= 1'b0;
      busy_q <= 1'b0;
      wel_q <= 1'b0;
      aai_q <= 1'b0;
      lvl_q <= LVL_RESET; // see [RULE11] [RULE16]
      lock_q <= LOCK_RESET; // see [RULE14] [RULE16]
      status_q <= {LOCK_RESET, 2'h0, LVL_RESET, 2'h0};
      deny_q <= 1'b1;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      out_q <= out_d;
      held_q <= held_d;
      so_q <= so_d;
      so_oe_q <= so_oe_d;
      cmd_byte_q <= cmd_byte_d;
      cmd_valid_q <= cmd_valid_d;
      busy_q <= busy_d;
      wel_q <= wel_d;
      aai_q <= aai_d;
      lvl_q <= lvl_d;
      lock_q <= lock_d;
      status_q <= status_d;
      deny_q <= deny_d;
    end
  end

  chk_hold_floats: assert property (@(posedge sys_clk) disable iff (!rst_b)
    held_q |=> !so_oe_q) else $error("output driven while paused"); // see [RULE4]
  chk_hold_entry: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!s2_q.ce_b && !s2_q.sck && !s2_q.hold_b && !held_q) |=> held_q)
    else $error("pause not entered with clock low"); // see [RULE2]
  chk_hold_defer: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!held_q && s2_q.sck) |=> !held_q) else $error("pause entered while clock high"); // see [RULE2]
  chk_hold_exit: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (held_q && !s2_q.ce_b && s2_q.sck) |=> held_q) else $error("pause left while clock high"); // see [RULE3]
  chk_ce_reset: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (held_q && s2_q.ce_b) |=> (!held_q && st_q == ST_IDLE))
    else $error("deselect did not reset paused interface"); // see [RULE5]
  chk_status_write_cmd_locked: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_go && !s2_q.wp_b && lock_q) |=> ($stable(lvl_q) && lock_q))
    else $error("locked status write accepted"); // see [RULE7]
  chk_status_write_cmd_taken: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_go && s2_q.wp_b) |=> ##1 (status_q[STAT_LVL_HI:STAT_LVL_LO] == $past(sh_q, 2)
      [STAT_LVL_HI:STAT_LVL_LO])) else $error("status write lost"); // see [RULE15]
  chk_wel_cleared: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_go && !wel_set) |=> !wel_q) else $error("latch kept after status write"); // see [RULE20]
  chk_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !status_q[STAT_RSVD]) else $error("reserved bit set"); // see [RULE12]
  chk_busy_mirror: assert property (@(posedge sys_clk) disable iff (!rst_b)
    eng_busy |=> status_q[STAT_BUSY])
    else $error("busy bit lags engine"); // see [RULE9]
  chk_chip_deny: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (chk.chip && lvl_q != 3'h0) |=> deny_q) else $error("whole erase allowed"); // see [RULE18]
  chk_busy_skip: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (busy_q && st_q == ST_OPC) |=> st_q != ST_WDATA)
    else $error("status write taken while busy"); // see [RULE17]
endmodule

// >>> sim/fsh_host.sv
// Serial host model that drives the flash pins in mode 0 with the clock idle low
`timescale 1ns/100ps
module fsh_host
  import fsh_pkg::*;
(
  input wire logic sys_clk,
  input wire logic so_q,
  output fsh_pkg::fsh_pins_t pins
);
  import fsh_pkg::*;
  logic ce_b = 1'h1;
  logic sck = 1'h0;
  logic si = 1'h0;
  logic hold_b = 1'h1;
  logic wp_b = 1'h1;
  assign pins = '{ce_b: ce_b, sck: sck, si: si, hold_b: hold_b, wp_b: wp_b};
  // Four system cycles per half period make the 200 ns link clock
  task automatic half(input logic lvl);
    sck <= lvl;
    repeat (4) @(posedge sys_clk);
  endtask
  // Enable only changes with the clock low; it stays low across a pause
  task automatic sel(input logic on);
    half(1'h0);
    ce_b <= ~on;
    // A released data line toggles so a stale bit never looks valid
    si <= ~si;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si <= tx[i];
      half(1'h0);
      half(1'h1);
      rx[i] = so_q;
    end
  endtask
endmodule

// >>> sim/flash_status_hold_bench.sv
// Self-checking bench for the status register, protect and pause block
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module flash_status_hold_bench;
  import fsh_pkg::*;
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic eng_busy = 1'h0;
  logic aai_active = 1'h0;
  logic wel_set = 1'h0;
  logic wel_clr = 1'h0;
  fsh_chk_t chk = '0;
  fsh_pins_t pins;
  logic so_q, so_oe_q, held_q, cmd_valid_q, deny_q;
  logic [7:0] status_q, cmd_byte_q, rx;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int valids = 0;
  always @(posedge sys_clk) begin
    if (cmd_valid_q === 1'b1) begin
      valids++;
    end
  end
  fsh_host i_fsh_host (.sys_clk(sys_clk), .so_q(so_q), .pins(pins));
  fsh_status_hold i_fsh_status_hold (.sys_clk(sys_clk), .rst_b(rst_b), .pins(pins),
    .eng_busy(eng_busy), .aai_active(aai_active), .wel_set(wel_set), .wel_clr(wel_clr),
    .chk(chk), .so_q(so_q), .so_oe_q(so_oe_q), .held_q(held_q), .status_q(status_q),
    .cmd_byte_q(cmd_byte_q), .cmd_valid_q(cmd_valid_q), .deny_q(deny_q));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic rdsr();
    i_fsh_host.sel(1'h1);
    i_fsh_host.xfer(8'h05, rx);
    i_fsh_host.xfer(8'h00, rx);
    i_fsh_host.sel(1'h0);
  endtask
  // Status update lands three cycles after enable rises; wait a little longer
  task automatic wsr(input logic [7:0] d);
    i_fsh_host.sel(1'h1);
    i_fsh_host.xfer(8'h01, rx);
    i_fsh_host.xfer(d, rx);
    i_fsh_host.sel(1'h0);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic probe(input logic [20:0] a, input logic c);
    @(posedge sys_clk) chk <= '{addr: a, chip: c};
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic pulse_wel(input logic set);
    @(posedge sys_clk) begin
      wel_set <= set;
      wel_clr <= ~set;
    end
    @(posedge sys_clk) begin
      wel_set <= 1'h0;
      wel_clr <= 1'h0;
    end
    @(posedge sys_clk);
  endtask
  task automatic t_power();
    int n;
    `CHK(status_q, 8'h1C)
    `CHK({held_q, so_oe_q, deny_q}, 3'h1)
    n = valids;
    rdsr();
    `CHK(rx, 8'h1C)
    `CHK(cmd_byte_q, OP_STATUS_READ)
    `CHK(valids, n + 1)
    $display("power-up test done");
  endtask
  task automatic t_write();
    pulse_wel(1'h1);
    `CHK(status_q[STAT_WEL], 1'h1)
    pulse_wel(1'h0);
    `CHK(status_q[STAT_WEL], 1'h0)
    pulse_wel(1'h1);
    wsr(8'h63);
    `CHK(status_q, 8'h00)
    `CHK(cmd_byte_q, OP_STATUS_WRITE)
    probe(21'h1FFFFF, 1'h1);
    `CHK(deny_q, 1'h0)
    wsr(8'hE8);
    `CHK(status_q, 8'h88)
    probe(21'h1E0000, 1'h0);
    `CHK(deny_q, 1'h1)
    probe(21'h1DFFFF, 1'h0);
    `CHK(deny_q, 1'h0)
    probe(21'h000000, 1'h1);
    `CHK(deny_q, 1'h1)
    $display("status write test done");
  endtask
  task automatic t_protect();
    @(posedge sys_clk) i_fsh_host.wp_b <= 1'h0;
    wsr(8'h00);
    `CHK(status_q, 8'h88)
    @(posedge sys_clk) i_fsh_host.wp_b <= 1'h1;
    wsr(8'h04);
    `CHK(status_q, 8'h04)
    @(posedge sys_clk) i_fsh_host.wp_b <= 1'h0;
    wsr(8'h14);
    `CHK(status_q, 8'h14)
    $display("write protect test done");
  endtask
  task automatic t_busy();
    int n;
    @(posedge sys_clk) begin
      eng_busy <= 1'h1;
      aai_active <= 1'h1;
    end
    repeat (2) @(posedge sys_clk);
    `CHK(status_q, 8'h55)
    n = valids;
    wsr(8'h00);
    `CHK(valids, n)
    rdsr();
    `CHK(rx, 8'h55)
    @(posedge sys_clk) begin
      eng_busy <= 1'h0;
      aai_active <= 1'h0;
    end
    repeat (2) @(posedge sys_clk);
    `CHK(status_q, 8'h14)
    $display("busy test done");
  endtask
  task automatic t_hold();
    i_fsh_host.sel(1'h1);
    i_fsh_host.xfer(8'h05, rx);
    i_fsh_host.xfer(8'h00, rx);
    i_fsh_host.half(1'h0);
    i_fsh_host.hold_b <= 1'h0;
    repeat (6) @(posedge sys_clk);
    `CHK({held_q, so_oe_q}, 2'h2)
    i_fsh_host.half(1'h1);
    i_fsh_host.half(1'h0);
    i_fsh_host.hold_b <= 1'h1;
    repeat (6) @(posedge sys_clk);
    `CHK(held_q, 1'h0)
    i_fsh_host.xfer(8'h00, rx);
    `CHK(rx, 8'h14)
    i_fsh_host.hold_b <= 1'h0;
    repeat (6) @(posedge sys_clk);
    `CHK(held_q, 1'h0)
    i_fsh_host.half(1'h0);
    `CHK(held_q, 1'h1)
    i_fsh_host.ce_b <= 1'h1;
    repeat (6) @(posedge sys_clk);
    `CHK(held_q, 1'h0)
    i_fsh_host.hold_b <= 1'h1;
    rdsr();
    `CHK(rx, 8'h14)
    $display("pause test done");
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'h1;
    repeat (4) @(posedge sys_clk);
    t_power();
    t_write();
    t_protect();
    t_busy();
    t_hold();
    final_report();
  end
endmodule
